// *** dgpc_change_det.v ***
`timescale 1ns/1ps
`default_nettype none

module dgpc_change_det #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // synchronised pins and their direction bits
    input wire [WIDTH-1:0] pin_lvl,
    input wire [WIDTH-1:0] dir_in,
    // any access of the second port
    input wire port_access,
    // mismatch summary
    output wire mismatch
);

reg [WIDTH-1:0] snap_ff;
wire [WIDTH-1:0] nxt_snap;

// snapshot refreshed on every read or write of the port
assign nxt_snap = port_access ? pin_lvl : snap_ff;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        snap_ff <= {WIDTH{1'b0}};
    end else begin
        snap_ff <= nxt_snap;
    end
end

// outputs excluded; access cycle masked so no change is judged against a stale copy
assign mismatch = (|((pin_lvl ^ snap_ff) & dir_in)) & ~port_access;

endmodule

`default_nettype wire

// *** dgpc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dgpc_checker #(
    parameter FIRST_W = 5,
    parameter SECOND_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_bset,
    input wire logic reg_bclr,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [FIRST_W-1:0] first_port_out,
    input wire logic [FIRST_W-1:0] first_port_oe,
    input wire logic [SECOND_W-1:0] second_port_in,
    input wire logic [SECOND_W-1:0] second_port_oe,
    input wire logic [SECOND_W-1:0] second_port_pullup_en,
    // analog and events
    input wire logic [FIRST_W-1:0] analog_input_sel,
    input wire logic [FIRST_W-1:0] digital_input_en,
    input wire logic port_change_flag,
    input wire logic wake_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire port_hit = (reg_rd | reg_wr | reg_bset | reg_bclr) && reg_addr == 8'h06;
    wire flag_clr = (reg_wr | reg_bclr) && reg_addr == 8'h0b;
    a_pullup_output: assert property ((second_port_pullup_en & second_port_oe) == 8'h00)
        else $error("pull-up on while pin drives");
    a_pullup_option: assert property (reg_wr && reg_addr == 8'h81 |=>
        second_port_pullup_en == ({8{~$past(reg_wdata[7])}} & ~second_port_oe))
        else $error("pull-ups do not follow option bit");
    a_second_dir: assert property (reg_wr && reg_addr == 8'h86 |=>
        second_port_oe == ~$past(reg_wdata)) else $error("second port drivers wrong");
    a_first_dir: assert property (reg_wr && reg_addr == 8'h85 |=>
        first_port_oe[3:0] == ~$past(reg_wdata[3:0])) else $error("first port drivers wrong");
    a_open_drain: assert property (first_port_out[4] == 1'b0)
        else $error("pin 4 drives high");
    a_digital_off: assert property (digital_input_en == ~analog_input_sel)
        else $error("digital input on an analog pin");
    a_first_read: assert property (reg_rd && reg_addr == 8'h05 |=>
        reg_rdata[7:5] == 3'h0 && (reg_rdata[4:0] & $past(analog_input_sel)) == 5'h00)
        else $error("first port read shows analog or high bits");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_flag_hold: assert property (port_change_flag && !flag_clr |=> port_change_flag)
        else $error("change flag dropped");
    a_change_flag: assert property (($changed(second_port_in[7:4]) && $past(rst_b, 4)
        && second_port_oe[7:4] == 4'h0 && !port_hit) ##1 (!port_hit && $stable(second_port_in)
        && second_port_oe[7:4] == 4'h0)[*4] |-> port_change_flag)
        else $error("change flag not set");
    a_wake_flag: assert property (wake_request |-> port_change_flag)
        else $error("wake without flag");
    a_cmp_off: assert property (reg_wr && reg_addr == 8'h1f && reg_wdata[2:0] == 3'h7 |=>
        analog_input_sel == 5'h00) else $error("comparator off leaves analog pins");
    cover property (reg_rd && reg_addr == 8'h06);
    cover property ($rose(port_change_flag));
    cover property (wake_request);
endmodule
bind dgpc_top dgpc_checker #(.FIRST_W(FIRST_W), .SECOND_W(SECOND_W)) chk (.mclk(mclk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_bset(reg_bset), .reg_bclr(reg_bclr), .reg_rdata(reg_rdata),
    .first_port_out(first_port_out), .first_port_oe(first_port_oe),
    .second_port_in(second_port_in), .second_port_oe(second_port_oe),
    .second_port_pullup_en(second_port_pullup_en), .analog_input_sel(analog_input_sel),
    .digital_input_en(digital_input_en), .port_change_flag(port_change_flag),
    .wake_request(wake_request));
`default_nettype wire

// *** dgpc_defines.vh ***
`ifndef DGPC_DEFINES_VH
`define DGPC_DEFINES_VH

// register offsets
`define DGPC_ADDR_W 8
`define DGPC_OFS_FIRST_DATA 8'h05
`define DGPC_OFS_SECOND_DATA 8'h06
`define DGPC_OFS_INT_CTRL 8'h0B
`define DGPC_OFS_CMP_CTRL 8'h1F
`define DGPC_OFS_OPTIONS 8'h81
`define DGPC_OFS_FIRST_DIR 8'h85
`define DGPC_OFS_SECOND_DIR 8'h86

// widths
`define DGPC_FIRST_W 5
`define DGPC_SECOND_W 8
`define DGPC_CHG_W 4

// reset values
`define DGPC_RST_OPTIONS 8'hFF
`define DGPC_RST_FIRST_DIR 5'h1F
`define DGPC_RST_SECOND_DIR 8'hFF
`define DGPC_RST_FIRST_DATA 5'h00
`define DGPC_RST_SECOND_DATA 8'h00
`define DGPC_RST_CMP_MODE 3'h0
`define DGPC_RST_INT_CTRL 2'h0

// field positions
`define DGPC_BIT_PULLUP_DIS_N 7
`define DGPC_BIT_CHG_FLAG 0
`define DGPC_BIT_CHG_EN 3
`define DGPC_BIT_CMP_MODE_LO 0
`define DGPC_BIT_CMP_MODE_HI 2
`define DGPC_BIT_CMP_SWAP 3
`define DGPC_BIT_CMP1_RES 6
`define DGPC_BIT_CMP2_RES 7
`define DGPC_BIT_OPEN_DRAIN 4
`define DGPC_BIT_CMP1_PIN 3
`define DGPC_BIT_CMP2_PIN 4

// comparator modes
`define DGPC_CMP_OFF 3'h7
`define DGPC_CMP_PIN_OUT 3'h6
`define DGPC_MASK_NONE 5'h00
`define DGPC_MASK_OUT_MODE 5'h07
`define DGPC_MASK_ALL_IN 5'h0F

`endif

// *** dgpc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dgpc_pin_model (
    // clock
    input wire logic mclk,
    // device side
    input wire logic [4:0] first_port_out,
    input wire logic [4:0] first_port_oe,
    input wire logic [7:0] second_port_out,
    input wire logic [7:0] second_port_oe,
    input wire logic [7:0] second_port_pullup_en,
    // outside drivers
    input wire logic [4:0] ext_a_en,
    input wire logic [4:0] ext_a_val,
    input wire logic [7:0] ext_b_en,
    input wire logic [7:0] ext_b_val,
    // resolved levels
    output logic [4:0] first_port_in,
    output logic [7:0] second_port_in
);
    // undriven pins without a pull-up toggle so a stale value never looks valid
    logic float_ff = 1'b0;
    always @(posedge mclk) begin
        float_ff <= ~float_ff;
    end
    // outside only drives released pins
    always @* begin
        for (int i = 0; i < 5; i++) begin
            first_port_in[i] = first_port_oe[i] ? first_port_out[i] :
                (ext_a_en[i] ? ext_a_val[i] : float_ff);
        end
        for (int i = 0; i < 8; i++) begin
            second_port_in[i] = second_port_oe[i] ? second_port_out[i] :
                (ext_b_en[i] ? ext_b_val[i] : (second_port_pullup_en[i] | float_ff));
        end
    end
endmodule
`default_nettype wire

// *** dgpc_sync.v ***
`timescale 1ns/1ps
`default_nettype none

module dgpc_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // asynchronous level in, synchronised level out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

// first stage feeds only the second stage
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        meta_ff <= {WIDTH{1'b0}};
        sync_ff <= {WIDTH{1'b0}};
    end else begin
        meta_ff <= async_in;
        sync_ff <= meta_ff;
    end
end

assign sync_out = sync_ff;

endmodule

`default_nettype wire

// *** dgpc_top.v ***
// Contract
// - first port is a 5-bit output latch; bits above 4 read zero.
// - direction one floats the pin, zero drives the latch value.
// - port reads return pin levels; writes only update the latch.
// - only bit set or clear is a read-modify-write; a plain port write stores reg_wdata in the latch.
// - bit set or clear reads all pins; input latch bits take pin level.
// - first-port pin 4 is open drain and feeds the timer clock.
// - first-port pins used as comparator inputs read as zero.
// - reset makes first port all inputs, digital inputs off on pins 0..3 (pin 4 stays digital), analog grounded.
// - direction bits still steer drivers in comparator-input use.
// - comparator output mode drives results onto first-port pins 3 and 4.
// - second port is 8-bit bidirectional with its own direction register.
// - clearing option bit 7 enables all second-port weak pull-ups.
// - a pull-up turns off while its pin is an output.
// - pull-ups are off after power-on reset.
// - only second-port pins 7..4 set as inputs join change detection.
// - inputs compared with copy from last port read or write; OR sets change flag.
// - change flag can wake the device from sleep.
// - mismatch keeps setting flag; any port access ends the mismatch.
// - a pin change during the port read sample may miss the flag.
// - second-port pin 0 also serves as external interrupt input.
// - writes land at end of cycle; read data sampled at cycle start.
`timescale 1ns/1ps
`default_nettype none
`include "dgpc_defines.vh"

module dgpc_top #(
    parameter FIRST_W = `DGPC_FIRST_W,
    parameter SECOND_W = `DGPC_SECOND_W,
    parameter CHG_W = `DGPC_CHG_W
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // register port
    input wire [`DGPC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // core bit operations on the addressed register
    input wire reg_bset,
    input wire reg_bclr,
    input wire [2:0] reg_bit,
    // first port pins
    input wire [FIRST_W-1:0] first_port_in,
    output wire [FIRST_W-1:0] first_port_out,
    output wire [FIRST_W-1:0] first_port_oe,
    // second port pins
    input wire [SECOND_W-1:0] second_port_in,
    output wire [SECOND_W-1:0] second_port_out,
    output wire [SECOND_W-1:0] second_port_oe,
    output wire [SECOND_W-1:0] second_port_pullup_en,
    // analog side
    input wire cmp1_result,
    input wire cmp2_result,
    output wire [FIRST_W-1:0] analog_input_sel,
    output wire [FIRST_W-1:0] digital_input_en,
    // shared-pin taps
    output wire timer_clock_in,
    output wire external_interrupt_in,
    output wire [6:0] timer_options,
    // change event
    output wire port_change_flag,
    output wire wake_request
);

// reset release through two flops
reg rst_meta_ff;
reg rst_sync_ff;
wire rst_n;

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rst_meta_ff <= 1'b0;
        rst_sync_ff <= 1'b0;
    end else begin
        rst_meta_ff <= 1'b1;
        rst_sync_ff <= rst_meta_ff;
    end
end

assign rst_n = rst_sync_ff;

// synchronised pin levels
wire [FIRST_W-1:0] first_lvl;
wire [SECOND_W-1:0] second_lvl;

dgpc_sync #(
    .WIDTH(FIRST_W)
) u_sync_first (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(first_port_in),
    .sync_out(first_lvl)
);

dgpc_sync #(
    .WIDTH(SECOND_W)
) u_sync_second (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(second_port_in),
    .sync_out(second_lvl)
);

// registers
reg [FIRST_W-1:0] first_data_ff;
reg [FIRST_W-1:0] first_dir_ff;
reg [SECOND_W-1:0] second_data_ff;
reg [SECOND_W-1:0] second_dir_ff;
reg [7:0] options_ff;
reg [2:0] cmp_mode_ff;
reg cmp_swap_ff;
reg chg_en_ff;
reg chg_flag_ff;
reg [7:0] rdata_ff;

reg [FIRST_W-1:0] nxt_first_data;
reg [FIRST_W-1:0] nxt_first_dir;
reg [SECOND_W-1:0] nxt_second_data;
reg [SECOND_W-1:0] nxt_second_dir;
reg [7:0] nxt_options;
reg [2:0] nxt_cmp_mode;
reg nxt_cmp_swap;
reg nxt_chg_en;
reg nxt_chg_flag;
wire [7:0] nxt_rdata;

// comparator mode to analog-input pin mask
function [4:0] analog_mask;
    input [2:0] mode;
    begin
        if (mode == `DGPC_CMP_OFF) begin
            analog_mask = `DGPC_MASK_NONE;
        end else if (mode == `DGPC_CMP_PIN_OUT) begin
            analog_mask = `DGPC_MASK_OUT_MODE;
        end else begin
            analog_mask = `DGPC_MASK_ALL_IN;
        end
    end
endfunction

// bit set or clear applied to a value read back
function [7:0] bit_modify;
    input [7:0] base;
    input [2:0] idx;
    input set_not_clr;
    reg [7:0] one_hot;
    begin
        one_hot = 8'h01 << idx;
        if (set_not_clr) begin
            bit_modify = base | one_hot;
        end else begin
            bit_modify = base & ~one_hot;
        end
    end
endfunction

wire [FIRST_W-1:0] ana_sel;
wire cmp_pin_out;
wire [FIRST_W-1:0] first_read;

assign ana_sel = analog_mask(cmp_mode_ff);
assign cmp_pin_out = (cmp_mode_ff == `DGPC_CMP_PIN_OUT);
// analog-selected pins read zero; digital path gated off
assign first_read = first_lvl & ~ana_sel;

// read view of each register
reg [7:0] read_view;

always @* begin
    if (reg_addr == `DGPC_OFS_FIRST_DATA) begin
        read_view = {3'h0, first_read};
    end else if (reg_addr == `DGPC_OFS_SECOND_DATA) begin
        read_view = second_lvl;
    end else if (reg_addr == `DGPC_OFS_FIRST_DIR) begin
        read_view = {3'h0, first_dir_ff};
    end else if (reg_addr == `DGPC_OFS_SECOND_DIR) begin
        read_view = second_dir_ff;
    end else if (reg_addr == `DGPC_OFS_OPTIONS) begin
        read_view = options_ff;
    end else if (reg_addr == `DGPC_OFS_INT_CTRL) begin
        read_view = 8'h00;
        read_view[`DGPC_BIT_CHG_EN] = chg_en_ff;
        read_view[`DGPC_BIT_CHG_FLAG] = chg_flag_ff;
    end else if (reg_addr == `DGPC_OFS_CMP_CTRL) begin
        read_view = 8'h00;
        read_view[`DGPC_BIT_CMP2_RES] = cmp2_result;
        read_view[`DGPC_BIT_CMP1_RES] = cmp1_result;
        read_view[`DGPC_BIT_CMP_SWAP] = cmp_swap_ff;
        read_view[`DGPC_BIT_CMP_MODE_HI:`DGPC_BIT_CMP_MODE_LO] = cmp_mode_ff;
    end else begin
        read_view = 8'h00;
    end
end

// a bit op stores the modified read view, so inputs take pin level; a plain write stores reg_wdata
wire any_wr;
wire [7:0] wr_val;

assign any_wr = reg_wr | reg_bset | reg_bclr;
assign wr_val = reg_wr ? reg_wdata : bit_modify(read_view, reg_bit, reg_bset);

// port read data sampled at the strobe, shown only in the next cycle
assign nxt_rdata = reg_rd ? read_view : 8'h00;

// second port access ends a pending mismatch
wire second_access;
wire chg_mismatch;

assign second_access = (reg_rd | any_wr) && (reg_addr == `DGPC_OFS_SECOND_DATA);

dgpc_change_det #(
    .WIDTH(CHG_W)
) u_change (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_lvl(second_lvl[SECOND_W-1:SECOND_W-CHG_W]),
    .dir_in(second_dir_ff[SECOND_W-1:SECOND_W-CHG_W]),
    .port_access(second_access),
    .mismatch(chg_mismatch)
);

// register next values
always @* begin
    nxt_first_data = first_data_ff;
    nxt_first_dir = first_dir_ff;
    nxt_second_data = second_data_ff;
    nxt_second_dir = second_dir_ff;
    nxt_options = options_ff;
    nxt_cmp_mode = cmp_mode_ff;
    nxt_cmp_swap = cmp_swap_ff;
    nxt_chg_en = chg_en_ff;
    nxt_chg_flag = chg_flag_ff;
    if (any_wr) begin
        if (reg_addr == `DGPC_OFS_FIRST_DATA) begin
            nxt_first_data = wr_val[FIRST_W-1:0];
        end else if (reg_addr == `DGPC_OFS_SECOND_DATA) begin
            nxt_second_data = wr_val;
        end else if (reg_addr == `DGPC_OFS_FIRST_DIR) begin
            nxt_first_dir = wr_val[FIRST_W-1:0];
        end else if (reg_addr == `DGPC_OFS_SECOND_DIR) begin
            nxt_second_dir = wr_val;
        end else if (reg_addr == `DGPC_OFS_OPTIONS) begin
            nxt_options = wr_val;
        end else if (reg_addr == `DGPC_OFS_INT_CTRL) begin
            nxt_chg_en = wr_val[`DGPC_BIT_CHG_EN];
            nxt_chg_flag = wr_val[`DGPC_BIT_CHG_FLAG];
        end else if (reg_addr == `DGPC_OFS_CMP_CTRL) begin
            nxt_cmp_mode = wr_val[`DGPC_BIT_CMP_MODE_HI:`DGPC_BIT_CMP_MODE_LO];
            nxt_cmp_swap = wr_val[`DGPC_BIT_CMP_SWAP];
        end
    end
    // a live mismatch wins over a software clear
    if (chg_mismatch) begin
        nxt_chg_flag = 1'b1;
    end
end

// writes land at the clock edge that ends the cycle
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        first_data_ff <= `DGPC_RST_FIRST_DATA;
        first_dir_ff <= `DGPC_RST_FIRST_DIR;
        second_data_ff <= `DGPC_RST_SECOND_DATA;
        second_dir_ff <= `DGPC_RST_SECOND_DIR;
        options_ff <= `DGPC_RST_OPTIONS;
        cmp_mode_ff <= `DGPC_RST_CMP_MODE;
        cmp_swap_ff <= 1'b0;
        chg_en_ff <= 1'b0;
        chg_flag_ff <= 1'b0;
        rdata_ff <= 8'h00;
    end else begin
        first_data_ff <= nxt_first_data;
        first_dir_ff <= nxt_first_dir;
        second_data_ff <= nxt_second_data;
        second_dir_ff <= nxt_second_dir;
        options_ff <= nxt_options;
        cmp_mode_ff <= nxt_cmp_mode;
        cmp_swap_ff <= nxt_cmp_swap;
        chg_en_ff <= nxt_chg_en;
        chg_flag_ff <= nxt_chg_flag;
        rdata_ff <= nxt_rdata;
    end
end

assign reg_rdata = rdata_ff;

// first port drivers
reg [FIRST_W-1:0] first_drive_val;

always @* begin
    first_drive_val = first_data_ff;
    // comparator results replace the latch on pins 3 and 4
    if (cmp_pin_out) begin
        first_drive_val[`DGPC_BIT_CMP1_PIN] = cmp1_result;
        first_drive_val[`DGPC_BIT_CMP2_PIN] = cmp2_result;
    end
end

// direction still rules the driver even for analog pins
reg [FIRST_W-1:0] first_oe_val;
reg [FIRST_W-1:0] first_out_val;

always @* begin
    first_oe_val = ~first_dir_ff;
    first_out_val = first_drive_val;
    // open drain: only ever pulls low
    first_oe_val[`DGPC_BIT_OPEN_DRAIN] = ~first_dir_ff[`DGPC_BIT_OPEN_DRAIN]
        & ~first_drive_val[`DGPC_BIT_OPEN_DRAIN];
    first_out_val[`DGPC_BIT_OPEN_DRAIN] = 1'b0;
end

assign first_port_oe = first_oe_val;
assign first_port_out = first_out_val;

// second port drivers
assign second_port_oe = ~second_dir_ff;
assign second_port_out = second_data_ff;

// one global enable, dropped per pin while it drives
assign second_port_pullup_en = {SECOND_W{~options_ff[`DGPC_BIT_PULLUP_DIS_N]}}
    & second_dir_ff;

// analog selection; grounding is done in the pad while selected
assign analog_input_sel = ana_sel;
assign digital_input_en = ~ana_sel;

// shared-pin taps, already synchronised; schmitt buffering lives in the pad
assign timer_clock_in = first_lvl[`DGPC_BIT_OPEN_DRAIN];
assign external_interrupt_in = second_lvl[0];
assign timer_options = options_ff[6:0];

// change flag and sleep wake, contention with a software clear resolved inside: mismatch wins
assign port_change_flag = chg_flag_ff;
assign wake_request = chg_flag_ff & chg_en_ff;

endmodule

`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk, rst_b, reg_wr, reg_rd, reg_bset, reg_bclr, cmp1_result, cmp2_result;
    logic [7:0] reg_addr, reg_wdata, ext_b_en, ext_b_val;
    logic [4:0] ext_a_en, ext_a_val;
    logic [2:0] reg_bit;
    wire [7:0] reg_rdata, second_port_in, second_port_out, second_port_oe, second_port_pullup_en;
    wire [4:0] first_port_in, first_port_out, first_port_oe, analog_input_sel, digital_input_en;
    wire port_change_flag, wake_request, timer_clock_in, external_interrupt_in;
    wire [6:0] timer_options;
    int miscompares, checks_done, cycles;
    dgpc_top uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_bset(reg_bset),
        .reg_bclr(reg_bclr), .reg_bit(reg_bit), .first_port_in(first_port_in),
        .first_port_out(first_port_out), .first_port_oe(first_port_oe),
        .second_port_in(second_port_in), .second_port_out(second_port_out),
        .second_port_oe(second_port_oe), .second_port_pullup_en(second_port_pullup_en),
        .cmp1_result(cmp1_result), .cmp2_result(cmp2_result),
        .analog_input_sel(analog_input_sel), .digital_input_en(digital_input_en),
        .timer_clock_in(timer_clock_in), .external_interrupt_in(external_interrupt_in),
        .timer_options(timer_options),
        .port_change_flag(port_change_flag), .wake_request(wake_request));
    dgpc_pin_model pins (.mclk(mclk), .first_port_out(first_port_out),
        .first_port_oe(first_port_oe), .second_port_out(second_port_out),
        .second_port_oe(second_port_oe), .second_port_pullup_en(second_port_pullup_en),
        .ext_a_en(ext_a_en), .ext_a_val(ext_a_val), .ext_b_en(ext_b_en),
        .ext_b_val(ext_b_val), .first_port_in(first_port_in), .second_port_in(second_port_in));
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask
    task automatic bop(input logic [2:0] b, input logic s);
        @(posedge mclk);
        reg_addr <= 8'h06;
        reg_bit <= b;
        reg_bset <= s;
        reg_bclr <= !s;
        @(posedge mclk);
        reg_bset <= 1'b0;
        reg_bclr <= 1'b0;
        #1;
    endtask
    // synchroniser plus flag latency, with margin
    task automatic settle;
        repeat (5) @(posedge mclk);
        #1;
    endtask
    task automatic t_reset;
        chk("second oe", 8'h00, second_port_oe);
        chk("pull-ups", 8'h00, second_port_pullup_en);
        chk("first oe", 8'h00, {3'h0, first_port_oe});
        chk("analog sel", 8'h0f, {3'h0, analog_input_sel});
        chk("digital en", 8'h10, {3'h0, digital_input_en});
        rd(8'h81, 8'hff, "options");
        rd(8'h85, 8'h1f, "first dir");
        rd(8'h86, 8'hff, "second dir");
        rd(8'h10, 8'h00, "unmapped");
        @(posedge mclk);
        ext_a_en <= 5'h1f;
        ext_a_val <= 5'h1f;
        settle;
        rd(8'h05, 8'h10, "first analog read");
        chk("timer clock", 8'h01, {7'h00, timer_clock_in});
        $display("reset test done");
    endtask
    task automatic t_first;
        wr(8'h1f, 8'h07);
        wr(8'h85, 8'h00);
        wr(8'h05, 8'h15);
        chk("first out", 8'h05, {3'h0, first_port_out});
        chk("first oe", 8'h0f, {3'h0, first_port_oe});
        settle;
        rd(8'h05, 8'h15, "first pins");
        wr(8'h05, 8'h05);
        chk("first oe low", 8'h1f, {3'h0, first_port_oe});
        settle;
        rd(8'h05, 8'h05, "first pins low");
        chk("timer clock low", 8'h00, {7'h00, timer_clock_in});
        @(posedge mclk);
        ext_a_val <= 5'h0a;
        wr(8'h85, 8'hff);
        chk("first oe off", 8'h00, {3'h0, first_port_oe});
        settle;
        rd(8'h05, 8'h0a, "first input pins");
        rd(8'h85, 8'h1f, "first dir high bits");
        $display("first port test done");
    endtask
    task automatic t_cmp;
        wr(8'h1f, 8'h06);
        @(posedge mclk);
        cmp1_result <= 1'b1;
        wr(8'h85, 8'h07);
        chk("cmp out", 8'h08, {3'h0, first_port_out} & 8'h18);
        chk("cmp oe", 8'h18, {3'h0, first_port_oe} & 8'h18);
        settle;
        rd(8'h05, 8'h08, "cmp mode read");
        rd(8'h1f, 8'h46, "cmp control");
        wr(8'h1f, 8'h07);
        $display("comparator test done");
    endtask
    task automatic t_rmw;
        @(posedge mclk);
        ext_b_en <= 8'hff;
        ext_b_val <= 8'ha0;
        wr(8'h86, 8'hf0);
        wr(8'h06, 8'h05);
        chk("second oe", 8'h0f, second_port_oe);
        settle;
        bop(3'h1, 1'b1);
        chk("bit set latch", 8'ha7, second_port_out);
        settle;
        bop(3'h7, 1'b0);
        chk("bit clear latch", 8'h27, second_port_out);
        $display("read-modify-write test done");
    endtask
    task automatic t_pullup;
        wr(8'h81, 8'h5a);
        chk("pull-ups on", 8'hf0, second_port_pullup_en);
        chk("timer options", 8'h5a, {1'b0, timer_options});
        @(posedge mclk);
        ext_b_en <= 8'h00;
        settle;
        rd(8'h06, 8'hf7, "pulled pins");
        chk("interrupt pin", 8'h01, {7'h00, external_interrupt_in});
        wr(8'h81, 8'hff);
        chk("pull-ups off", 8'h00, second_port_pullup_en);
        $display("pull-up test done");
    endtask
    task automatic t_change;
        @(posedge mclk);
        ext_b_en <= 8'hff;
        settle;
        rd(8'h06, 8'ha7, "second pins");
        wr(8'h0b, 8'h08);
        chk("flag clear", 8'h00, {7'h00, port_change_flag});
        @(posedge mclk);
        ext_b_val <= 8'hb8;
        settle;
        chk("flag set", 8'h01, {7'h00, port_change_flag});
        chk("wake", 8'h01, {7'h00, wake_request});
        wr(8'h0b, 8'h08);
        chk("clear refused", 8'h01, {7'h00, port_change_flag});
        rd(8'h0b, 8'h09, "int control");
        rd(8'h06, 8'hb7, "second pins");
        wr(8'h0b, 8'h08);
        chk("flag cleared", 8'h00, {7'h00, port_change_flag});
        wr(8'h86, 8'hff);
        settle;
        chk("low pins ignored", 8'h00, {7'h00, port_change_flag});
        chk("interrupt pin low", 8'h00, {7'h00, external_interrupt_in});
        $display("change test done");
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        rst_b = 1'b0;
        {reg_wr, reg_rd, reg_bset, reg_bclr, cmp1_result, cmp2_result} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_bit = 3'h0;
        ext_a_en = 5'h00;
        ext_a_val = 5'h00;
        ext_b_en = 8'h00;
        ext_b_val = 8'h00;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        t_reset;
        t_first;
        t_cmp;
        t_rmw;
        t_pullup;
        t_change;
        complete_run;
    end
endmodule
`default_nettype wire
